/* ldcs_sequencer.sv */
module ldcs_sequencer
	import ldcs_pkg::*;
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// AXI4-Lite register port
	input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [AXI_AW-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	// Instruction decode strobes
	input  wire logic                instr_done,
	input  wire logic [ADDR_W-1:0]   instr_addr,
	input  wire logic                loop_open,
	input  wire logic                loop_close_instruction,
	input  wire logic                counter_load,
	input  wire logic                match_load,
	input  wire logic                src_from_cpu,
	input  wire logic [ADDR_W-1:0]   const_value,
	input  wire logic [ADDR_W-1:0]   cpu_value,
	// Return stack requests from call and return logic
	input  wire logic                call_push,
	input  wire logic [ADDR_W-1:0]   call_push_data,
	input  wire logic                ret_pop,
	// CPU result
	input  wire logic                alu_done,
	input  wire logic [DATA_W-1:0]   alu_result,
	input  wire logic                alu_carry,
	input  wire logic                alu_overflow,
	// Queue, host and interrupt status
	input  wire logic [7:0]          user_test_inputs,
	input  wire logic                host_bus_bit5,
	input  wire logic                queue_full,
	input  wire logic                queue_empty,
	input  wire logic                queue_read_cmd,
	input  wire logic                queue_read_data,
	input  wire logic                dout_write,
	input  wire logic                host_dout_read,
	input  wire logic                irq_pending,
	// Condition test and case requests
	input  wire logic                cond_req,
	input  wire logic [SEL_W-1:0]    cond_sel,
	input  wire logic                cond_invert,
	input  wire logic [4*SEL_W-1:0]  case_sel,
	// Results
	output logic [ADDR_W-1:0]        iteration_counter,
	output logic                     loop_repeat,
	output logic [ADDR_W-1:0]        stack_top,
	output logic                     debug_irq,
	output logic                     stack_overflow_irq,
	output logic                     cond_result,
	output logic [3:0]               case_index,
	output logic                     queue_in_ready,
	output logic                     host_read_done_flag
);

	logic [MASK_W-1:0]          mask;
	logic [ADDR_W-1:0]          debug_match_reg;
	logic [7:0]                 user_meta;
	logic [7:0]                 user_sync;
	logic                       bit5_meta;
	logic                       queue_cmd_flag;
	logic                       carry_flag;
	logic                       zero_flag;
	logic                       ovf_flag;
	logic                       sign_flag;
	logic                       flag_valid;
	logic                       queue_type_error;
	logic                       stack_full_flag;
	logic                       pending_irq_flag;
	logic                       queue_out_ready;
	logic                       loop_active;
	logic [3:0]                 nest_depth;
	logic [ADDR_W-1:0]          stack_mem [STACK_LEVELS];
	logic [3:0]                 sp;
	logic                       push_en;
	logic [ADDR_W-1:0]          push_data;
	logic                       pop_en;
	logic [ADDR_W-1:0]          pop_data;
	logic [ADDR_W-1:0]          load_value;
	logic [NUM_COND-1:0]        cond_vec;
	logic [NUM_COND-1:0]        cond_gated;
	logic                       wr_fire;
	logic                       status_clr_err;
	logic [31:0]                next_rdata;
	logic [1:0]                 next_rresp;

	// Test inputs and host bus bit 5 pass two flops; only the second is read
	always_ff @(posedge ref_clk)
	begin
		user_meta      <= user_test_inputs; // [RULE14]
		user_sync      <= user_meta;
		bit5_meta      <= host_bus_bit5;
		queue_cmd_flag <= bit5_meta; // [RULE18]
	end

	// Source select shared by counter and match loads
	assign load_value = src_from_cpu ? cpu_value : const_value; // [RULE3] [RULE4] [RULE8]

	// Stack requests: loop traffic has the instruction slot, so it wins
	always_comb
	begin
		push_en   = 1'b0;
		push_data = iteration_counter;
		pop_en    = 1'b0;
		if (loop_open && loop_active)
		begin
			push_en = 1'b1; // [RULE6]
		end
		else if (loop_close_instruction && iteration_counter == '0 && nest_depth != '0)
		begin
			pop_en = 1'b1; // [RULE7]
		end
		else if (call_push)
		begin
			push_en   = 1'b1;
			push_data = call_push_data;
		end
		else if (ret_pop)
		begin
			pop_en = 1'b1;
		end
	end

	// Empty pop reads slot 0, which holds the last top popped
	assign pop_data = (sp == '0) ? stack_mem[0] : stack_mem[sp - 4'h1]; // [RULE24]

	// Return stack storage
	always_ff @(posedge ref_clk)
	begin
		if (push_en)
		begin
			if (sp == 4'(STACK_LEVELS))
			begin
				stack_mem[STACK_LEVELS-1] <= push_data; // [RULE24]
			end
			else
			begin
				stack_mem[sp] <= push_data;
			end
		end
	end

	// Stack pointer, full flag and popped value
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			sp              <= '0;
			stack_full_flag <= 1'b0;
			stack_top       <= '0;
		end
		else
		begin
			if (push_en && sp != 4'(STACK_LEVELS))
			begin
				sp <= sp + 4'h1;
			end
			else if (pop_en && sp != '0)
			begin
				sp <= sp - 4'h1;
			end
			if (pop_en)
			begin
				stack_top <= pop_data;
			end
			stack_full_flag <= (sp == 4'(STACK_LEVELS)) // [RULE20]
				|| (push_en && sp == 4'(STACK_LEVELS - 1))
				? !(pop_en && !push_en) : 1'b0;
		end
	end

	// Loop counter and nesting
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			iteration_counter <= COUNT_RESET;
			loop_active       <= 1'b0;
			nest_depth        <= '0;
			loop_repeat       <= 1'b0;
		end
		else
		begin
			loop_repeat <= 1'b0;
			if (loop_open)
			begin
				iteration_counter <= load_value; // [RULE1] [RULE2] [RULE4]
				loop_active       <= 1'b1;
				if (loop_active && nest_depth != 4'hf)
				begin
					nest_depth <= nest_depth + 4'h1; // [RULE6]
				end
			end
			else if (loop_close_instruction)
			begin
				if (iteration_counter != '0)
				begin
					iteration_counter <= iteration_counter - 10'h001; // [RULE5]
					loop_repeat       <= 1'b1;
				end
				else if (nest_depth != '0)
				begin
					iteration_counter <= pop_data; // [RULE7]
					nest_depth        <= nest_depth - 4'h1;
				end
				else
				begin
					loop_active <= 1'b0;
				end
			end
			else if (counter_load)
			begin
				iteration_counter <= load_value; // [RULE3]
			end
		end
	end

	// Debug match register; program load has priority over the bus
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			debug_match_reg <= MATCH_RESET;
		end
		else if (match_load)
		begin
			debug_match_reg <= load_value; // [RULE8]
		end
		else if (wr_fire && s_axi_awaddr == OFS_MATCH)
		begin
			debug_match_reg <= s_axi_wdata[ADDR_W-1:0];
		end
	end

	// Debug interrupt fires once the instruction has completed, so the
	// matching instruction still executes
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			debug_irq <= 1'b0;
		end
		else if (mask[MASK_STEP_BIT])
		begin
			debug_irq <= instr_done; // [RULE10] [RULE11]
		end
		else
		begin
			debug_irq <= instr_done && instr_addr == debug_match_reg; // [RULE9] [RULE25]
		end
	end

	// Arithmetic flags hold for one instruction after the operation
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			carry_flag <= 1'b0;
			zero_flag  <= 1'b0;
			ovf_flag   <= 1'b0;
			sign_flag  <= 1'b0;
			flag_valid <= 1'b0;
		end
		else if (alu_done)
		begin
			carry_flag <= alu_carry; // [RULE16]
			zero_flag  <= alu_result == '0;
			ovf_flag   <= alu_overflow;
			sign_flag  <= alu_result[DATA_W-1];
			flag_valid <= 1'b1; // [RULE15]
		end
		else if (instr_done)
		begin
			flag_valid <= 1'b0; // [RULE15]
		end
	end

	// Queue, stack and interrupt status flags
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			queue_in_ready      <= 1'b0;
			queue_out_ready     <= 1'b0;
			queue_type_error    <= 1'b0;
			pending_irq_flag    <= 1'b0;
			stack_overflow_irq  <= 1'b0;
			host_read_done_flag <= 1'b0;
		end
		else
		begin
			queue_in_ready     <= !queue_full; // [RULE17]
			queue_out_ready    <= !queue_empty;
			pending_irq_flag   <= irq_pending; // [RULE21]
			stack_overflow_irq <= stack_full_flag && !mask[MASK_STK_BIT]; // [RULE20]
			// A new mismatch beats a clear in the same cycle
			if ((queue_read_cmd && !queue_cmd_flag) || (queue_read_data && queue_cmd_flag))
			begin
				queue_type_error <= 1'b1; // [RULE19]
			end
			else if (status_clr_err)
			begin
				queue_type_error <= 1'b0;
			end
			if (host_dout_read)
			begin
				host_read_done_flag <= 1'b1; // [RULE23]
			end
			else if (dout_write)
			begin
				host_read_done_flag <= 1'b0; // [RULE23]
			end
		end
	end

	// Condition vector; arithmetic flags read false once stale
	assign cond_vec = {
		(instr_addr == debug_match_reg), (iteration_counter == '0),
		host_read_done_flag, pending_irq_flag, stack_full_flag, // [RULE22]
		queue_type_error, queue_cmd_flag, queue_out_ready, queue_in_ready,
		sign_flag && flag_valid, ovf_flag && flag_valid,
		zero_flag && flag_valid, carry_flag && flag_valid, user_sync}; // [RULE12]

	// Out-of-range condition selects read as false; case selects are not range-checked
	generate
		for (genvar i = 0; i < NUM_COND; i++)
		begin : g_cond
			assign cond_gated[i] = cond_vec[i];
		end
	endgenerate

	// Condition test and four-bit case index
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			cond_result <= 1'b0;
			case_index  <= '0;
		end
		else if (cond_req)
		begin
			cond_result <= (cond_sel < SEL_W'(NUM_COND) && cond_gated[cond_sel]) ^ cond_invert; // [RULE12]
			for (int k = 0; k < 4; k++)
			begin
				case_index[k] <= cond_gated[case_sel[k*SEL_W +: SEL_W]]; // [RULE13]
			end
		end
	end

	// Write channel takes address and data together, one at a time
	assign wr_fire        = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign status_clr_err = wr_fire && s_axi_awaddr == OFS_STATUS
		&& s_axi_wstrb[0] && s_axi_wdata[ST_TYPE_ERR];

	// Write response and mask register
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			mask          <= MASK_RESET;
		end
		else
		begin
			s_axi_awready <= wr_fire;
			s_axi_wready  <= wr_fire;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (s_axi_awaddr == OFS_COUNTER) ? RESP_SLVERR : RESP_OKAY;
				if (s_axi_awaddr == OFS_MASK)
				begin
					if (s_axi_wstrb[0])
					begin
						mask[7:0] <= s_axi_wdata[7:0];
					end
					if (s_axi_wstrb[1])
					begin
						mask[8] <= s_axi_wdata[8]; // [RULE11]
					end
				end
			end
			else if (s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data mux
	always_comb
	begin
		next_rdata = '0;
		next_rresp = RESP_OKAY;
		case (s_axi_araddr)
			OFS_MASK:    next_rdata[MASK_W-1:0] = mask;
			OFS_STATUS:
			begin
				next_rdata[ST_CARRY]      = carry_flag;
				next_rdata[ST_ZERO]       = zero_flag;
				next_rdata[ST_OVF]        = ovf_flag;
				next_rdata[ST_SIGN]       = sign_flag;
				next_rdata[ST_IN_READY]   = queue_in_ready;
				next_rdata[ST_CMD]        = queue_cmd_flag;
				next_rdata[ST_TYPE_ERR]   = queue_type_error;
				next_rdata[ST_STK_FULL]   = stack_full_flag;
				next_rdata[ST_PEND_IRQ]   = pending_irq_flag;
				next_rdata[ST_FLAG_VALID] = flag_valid;
				next_rdata[ST_NEST_LSB +: 4] = nest_depth;
			end
			OFS_COUNTER: next_rdata[ADDR_W-1:0] = iteration_counter;
			OFS_MATCH:   next_rdata[ADDR_W-1:0] = debug_match_reg;
			default:     next_rresp = RESP_SLVERR;
		endcase
	end

	// Read channel: one outstanding read
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
			begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= next_rdata;
				s_axi_rresp   <= next_rresp;
			end
			else if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	property p_close_dec;
		@(posedge ref_clk) disable iff (rst)
		loop_close_instruction && !loop_open && iteration_counter != '0
		|=> loop_repeat && iteration_counter == $past(iteration_counter) - 10'h001;
	endproperty
	a_close_dec: assert property (p_close_dec) else $error("counter did not decrement"); // [RULE5]

	property p_close_exit;
		@(posedge ref_clk) disable iff (rst)
		loop_close_instruction && !loop_open && iteration_counter == '0 |=> !loop_repeat;
	endproperty
	a_close_exit: assert property (p_close_exit) else $error("loop repeated at zero"); // [RULE5]

	property p_step;
		@(posedge ref_clk) disable iff (rst)
		mask[MASK_STEP_BIT] && instr_done |=> debug_irq;
	endproperty
	a_step: assert property (p_step) else $error("single step missed"); // [RULE10]

	property p_break;
		@(posedge ref_clk) disable iff (rst)
		!mask[MASK_STEP_BIT] ##0 instr_done ##0 instr_addr == debug_match_reg |=> debug_irq;
	endproperty
	a_break: assert property (p_break) else $error("breakpoint missed"); // [RULE9]

	property p_no_spurious;
		@(posedge ref_clk) disable iff (rst)
		!instr_done |=> !debug_irq;
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("debug irq without instr"); // [RULE25]

	property p_read_done;
		@(posedge ref_clk) disable iff (rst)
		dout_write && !host_dout_read ##1 !host_dout_read [*2] |-> !host_read_done_flag;
	endproperty
	a_read_done: assert property (p_read_done) else $error("read-done not cleared"); // [RULE23]

	property p_stk_irq;
		@(posedge ref_clk) disable iff (rst)
		stack_full_flag && !mask[MASK_STK_BIT] |=> stack_overflow_irq;
	endproperty
	a_stk_irq: assert property (p_stk_irq) else $error("stack irq missing"); // [RULE20]

	property p_full;
		@(posedge ref_clk) disable iff (rst)
		$rose(stack_full_flag) |-> $past(sp) == 4'(STACK_LEVELS - 1);
	endproperty
	a_full: assert property (p_full) else $error("full flag at wrong depth"); // [RULE20]

	property p_in_ready;
		@(posedge ref_clk) disable iff (rst)
		queue_full |=> !queue_in_ready;
	endproperty
	a_in_ready: assert property (p_in_ready) else $error("in-ready while full"); // [RULE17]

	property p_flag_stale;
		@(posedge ref_clk) disable iff (rst)
		instr_done && !alu_done |=> !flag_valid;
	endproperty
	a_flag_stale: assert property (p_flag_stale) else $error("flags outlived instruction"); // [RULE15]

	property p_type_err;
		@(posedge ref_clk) disable iff (rst)
		queue_read_data && queue_cmd_flag |=> queue_type_error;
	endproperty
	a_type_err: assert property (p_type_err) else $error("type error not set"); // [RULE19]

endmodule

/* ldcs_pkg.sv */
// What this block does
// [RULE1] Ten-bit down counter drives loop instructions
// [RULE2] Counter accepts any value 0 to 1023
// [RULE3] Counter loads from CPU or constant; jump target
// [RULE4] Loop open loads fixed or computed count
// [RULE5] Loop close: nonzero decrements and repeats, zero exits
// [RULE6] Nested loop open pushes old count first
// [RULE7] Nested loop exit restores count from stack
// [RULE8] Ten-bit match register, constant or CPU loaded
// [RULE9] Breakpoint mode: address match raises debug interrupt
// [RULE10] Single-step mode: interrupt after every instruction
// [RULE11] Mask bit 8 selects breakpoint or single-step
// [RULE12] Twenty-one conditions, each testable true or false
// [RULE13] Case branching tests four conditions at once
// [RULE14] External test inputs must meet setup time
// [RULE15] Arithmetic flags valid only for next instruction
// [RULE16] Zero, carry, overflow, sign flags from CPU result
// [RULE17] Queue input ready high while queue not full
// [RULE18] Queue command flag follows host bus bit 5
// [RULE19] Type error when entry read as wrong kind
// [RULE20] Stack full at fifteen levels, unmasked interrupt
// [RULE21] Pending interrupt flag follows masked pending interrupt
// [RULE22] Host read-done flag visible only to program
// [RULE23] Output write clears read-done; host read sets it
// [RULE24] Full push overwrites top; empty pop repeats top
// [RULE25] Breakpoint on fetched address, taken after completion
package ldcs_pkg;
	localparam int          ADDR_W        = 10;
	localparam int          DATA_W        = 16;
	localparam int          STACK_LEVELS  = 15;
	localparam int          NUM_COND      = 21;
	localparam int          SEL_W         = 5;
	localparam int          AXI_AW        = 4;
	// Register byte offsets
	localparam logic [3:0]  OFS_MASK      = 4'h0;
	localparam logic [3:0]  OFS_STATUS    = 4'h4;
	localparam logic [3:0]  OFS_COUNTER   = 4'h8;
	localparam logic [3:0]  OFS_MATCH     = 4'hc;
	// Mask register fields
	localparam int          MASK_W        = 9;
	localparam int          MASK_STK_BIT  = 7;
	localparam int          MASK_STEP_BIT = 8;
	localparam logic [8:0]  MASK_RESET    = 9'h000;
	localparam logic [9:0]  MATCH_RESET   = 10'h000;
	localparam logic [9:0]  COUNT_RESET   = 10'h000;
	// Status register fields, write one to clear the type error
	localparam int          ST_CARRY      = 0;
	localparam int          ST_ZERO       = 1;
	localparam int          ST_OVF        = 2;
	localparam int          ST_SIGN       = 3;
	localparam int          ST_IN_READY   = 4;
	localparam int          ST_CMD        = 5;
	localparam int          ST_TYPE_ERR   = 6;
	localparam int          ST_STK_FULL   = 7;
	localparam int          ST_PEND_IRQ   = 8;
	localparam int          ST_FLAG_VALID = 9;
	localparam int          ST_NEST_LSB   = 12;
	// Condition numbers 0..7 are the user test inputs
	localparam int          CND_CARRY     = 8;
	localparam int          CND_ZERO      = 9;
	localparam int          CND_OVF       = 10;
	localparam int          CND_SIGN      = 11;
	localparam int          CND_IN_READY  = 12;
	localparam int          CND_OUT_READY = 13;
	localparam int          CND_CMD       = 14;
	localparam int          CND_TYPE_ERR  = 15;
	localparam int          CND_STK_FULL  = 16;
	localparam int          CND_PEND_IRQ  = 17;
	localparam int          CND_READ_DONE = 18;
	localparam int          CND_CNT_ZERO  = 19;
	localparam int          CND_DBG_HIT   = 20;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;
endpackage

/* ldcs_host_model.sv */
module ldcs_host_model
	import ldcs_pkg::*;
#(
	parameter int DEPTH = 4
)
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Bench requests and device strobes
	input  wire logic       push,
	input  wire logic       push_cmd,
	input  wire logic       pop,
	input  wire logic       dout_write,
	input  wire logic [2:0] lag,
	// Host side levels
	output logic            queue_full,
	output logic            queue_empty,
	output logic            host_bus_bit5,
	output logic            host_dout_read
);
	timeunit 1ns;
	timeprecision 100ps;
	logic q[$];
	logic last_v = 1'b0;
	int   wait_n = 0;
	// Queue of entry kinds; an empty queue shows the flipped level, never a stale one
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			q = {};
			wait_n = 0;
		end
		else
		begin
			if (push && q.size() < DEPTH)
				q.push_back(push_cmd);
			if (pop && q.size() > 0)
				void'(q.pop_front());
			if (dout_write)
				wait_n = lag + 1;
			else if (wait_n > 0)
				wait_n--;
		end
		if (q.size() > 0)
			last_v = q[0];
		queue_full <= (q.size() == DEPTH);
		queue_empty <= (q.size() == 0);
		host_bus_bit5 <= (q.size() > 0) ? q[0] : ~last_v;
		host_dout_read <= (wait_n == 1);
	end
endmodule

/* loop_debug_condition_sequencer_test.sv */
module loop_debug_condition_sequencer_test
	import ldcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	// Design ports
	logic                ref_clk = 1'b0;
	logic                rst = 1'b1;
	logic [AXI_AW-1:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]         s_axi_wdata, s_axi_rdata;
	logic [3:0]          s_axi_wstrb, case_index;
	logic [1:0]          s_axi_bresp, s_axi_rresp;
	logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                s_axi_rvalid, s_axi_rready, instr_done, loop_open;
	logic                loop_close_instruction, counter_load, match_load, src_from_cpu;
	logic                call_push, ret_pop, alu_done, alu_carry, alu_overflow;
	logic                host_bus_bit5, queue_full, queue_empty, queue_read_cmd;
	logic                queue_read_data, dout_write, host_dout_read, irq_pending;
	logic                cond_req, cond_invert, loop_repeat, debug_irq, cond_result;
	logic                stack_overflow_irq, queue_in_ready, host_read_done_flag;
	logic [ADDR_W-1:0]   instr_addr, const_value, cpu_value, call_push_data;
	logic [ADDR_W-1:0]   iteration_counter, stack_top;
	logic [DATA_W-1:0]   alu_result;
	logic [7:0]          user_test_inputs;
	logic [SEL_W-1:0]    cond_sel;
	logic [4*SEL_W-1:0]  case_sel;
	// Partner controls and reference model
	logic                h_push, h_cmd, m_step, m_terr;
	logic [2:0]          h_lag;
	logic [3:0]          cx;
	logic [20:0]         ev;
	logic [31:0]         rd;
	logic [1:0]          rs;
	int                  mismatches = 0, num_checks = 0, seed = 32'h06b365cf;
	int                  m_cnt = 0, m_dep = 0, m_mt = 0;
	int                  m_stk[$];

	always #12.5 ref_clk = ~ref_clk;

	ldcs_sequencer dut (.*);

	ldcs_host_model host (.ref_clk, .rst, .push(h_push), .push_cmd(h_cmd),
		.pop(queue_read_cmd | queue_read_data), .dout_write, .lag(h_lag),
		.queue_full, .queue_empty, .host_bus_bit5, .host_dout_read);

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Address and data go out together; each is dropped once its ready is seen
	task automatic axw(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axr(input logic [3:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		{rd, rs} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
	endtask

	// One instruction, k = {match, counter, close, open}; the unused source gets ~v
	task automatic ins(input logic [3:0] k, input int v, input int a, input logic c);
		int rep;
		rep = 0;
		@(posedge ref_clk);
		{match_load, counter_load, loop_close_instruction, loop_open} <= k;
		{instr_done, src_from_cpu, instr_addr} <= {1'b1, c, 10'(a)};
		cpu_value <= 10'(c ? v : ~v);
		const_value <= 10'(c ? ~v : v);
		@(posedge ref_clk);
		{match_load, counter_load, loop_close_instruction, loop_open, instr_done} <= 5'h0;
		#1;
		chk("irq", debug_irq, m_step || a == m_mt);
		if (k[0])
		begin
			if (m_dep > 0)
				m_stk.push_back(m_cnt);
			m_cnt = v;
			m_dep++;
		end
		else if (k[1] && m_cnt != 0)
		begin
			m_cnt--;
			rep = 1;
		end
		else if (k[1])
		begin
			if (m_dep > 1)
				m_cnt = m_stk.pop_back();
			m_dep--;
		end
		else if (k[2])
			m_cnt = v;
		if (k[3])
			m_mt = v;
		chk("count", iteration_counter, m_cnt);
		chk("repeat", loop_repeat, rep);
	endtask

	task automatic cnd(input int s, input logic inv);
		@(posedge ref_clk);
		{cond_req, cond_invert, cond_sel} <= {1'b1, inv, 5'(s)};
		@(posedge ref_clk);
		cond_req <= 1'b0;
		#1;
		chk("cond", cond_result, inv ^ (s < 21 && ev[s]));
	endtask

	// Main sequence
	initial
	begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {8'h0, 32'h0, 4'hf};
		{instr_done, loop_open, loop_close_instruction, counter_load, match_load} = 5'h0;
		{src_from_cpu, call_push, ret_pop, alu_done, alu_carry, alu_overflow} = 6'h0;
		{queue_read_cmd, queue_read_data, dout_write, irq_pending, cond_req} = 5'h0;
		{cond_invert, h_push, h_cmd, h_lag, m_step, m_terr} = 8'h0;
		{instr_addr, const_value, cpu_value, call_push_data} = 40'h0;
		{alu_result, user_test_inputs, cond_sel, case_sel, ev} = 70'h0;
		repeat (12) @(posedge ref_clk);
		rst <= 1'b0;
		// Step mode interrupts every instruction, breakpoint mode only on a match
		axw(OFS_MASK, 32'h100);
		axr(OFS_MASK);
		chk("mask", rd, 32'h100);
		m_step = 1'b1;
		ins(4'h0, 0, 5, 1'b0);
		ins(4'h0, 0, 6, 1'b0);
		axw(OFS_MASK, 32'h0);
		m_step = 1'b0;
		ins(4'h8, 10'h155, 3, 1'b1);
		ins(4'h0, 0, 10'h155, 1'b0);
		ins(4'h0, 0, 10'h154, 1'b0);
		// The counter is read-only on the bus; an unmapped read is refused
		axw(OFS_COUNTER, 32'h1);
		chk("cnt_wr", rs, RESP_SLVERR);
		axr(4'h2);
		chk("unmapped", rs, RESP_SLVERR);
		ins(4'h4, 1023, 7, 1'b1);
		axr(OFS_COUNTER);
		chk("cnt_rd", rd, 1023);
		// Nested loops with random counts, including zero
		for (int i = 0; i < 2; i++)
		begin
			ins(4'h1, $random(seed) & 3, 7, i[0]);
			ins(4'h1, $random(seed) & 3, 8, 1'b0);
			repeat (m_cnt + 1) ins(4'h2, 0, 9, 1'b0);
			repeat (m_cnt + 1) ins(4'h2, 0, 9, 1'b0);
		end
		// Fill the queue with commands, then read one right and one wrong
		@(posedge ref_clk);
		{h_push, h_cmd} <= 2'h3;
		repeat (4) @(posedge ref_clk);
		h_push <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("in_ready", queue_in_ready, 0);
		queue_read_cmd <= 1'b1;
		@(posedge ref_clk);
		queue_read_cmd <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("in_ready", queue_in_ready, 1);
		queue_read_data <= 1'b1;
		@(posedge ref_clk);
		queue_read_data <= 1'b0;
		m_terr = 1'b1;
		// Output write clears the handshake until the host reads after its own delay
		h_lag <= 3'($random(seed));
		dout_write <= 1'b1;
		@(posedge ref_clk);
		dout_write <= 1'b0;
		@(posedge ref_clk);
		chk("rd_done", host_read_done_flag, 0);
		for (int i = 0; i < 12 && host_read_done_flag !== 1'b1; i++)
			@(posedge ref_clk);
		chk("rd_done", host_read_done_flag, 1);
		// Every condition and two out-of-range selects, each with a random polarity, for a zero and a random result
		user_test_inputs <= 8'($random(seed));
		irq_pending <= 1'b1;
		for (int j = 0; j < 2; j++)
		begin
			@(posedge ref_clk);
			{alu_result, alu_carry, alu_overflow, alu_done} <=
				{j ? 16'($random(seed)) : 16'h0, j[0], !j[0], 1'b1};
			@(posedge ref_clk);
			alu_done <= 1'b0;
			ev[11:8] = {alu_result[15], alu_overflow, alu_result == 16'h0, alu_carry};
			ev = {instr_addr == 10'(m_mt), m_cnt == 0, 3'b110, m_terr, 3'b111, ev[11:0]};
			ev[7:0] = user_test_inputs;
			for (int i = 0; i < 23; i++)
				cnd(i, 1'($random(seed)));
		end
		for (int k = 0; k < 4; k++)
			case_sel[5 * k +: 5] <= 5'($random(seed) & 15);
		@(posedge ref_clk);
		for (int k = 0; k < 4; k++)
			cx[k] = ev[case_sel[5 * k +: 5]];
		cnd(19, 1'b0);
		chk("case", case_index, cx);
		ins(4'h0, 0, 9, 1'b0);
		ev[11:8] = 4'h0;
		cnd(8, 1'b0);
		// Fill the stack, push over the top, then pop it back
		@(posedge ref_clk);
		call_push <= 1'b1;
		repeat (15) @(posedge ref_clk);
		call_push_data <= 10'h3aa;
		@(posedge ref_clk);
		call_push <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("stk_irq", stack_overflow_irq, 1);
		ret_pop <= 1'b1;
		@(posedge ref_clk);
		ret_pop <= 1'b0;
		@(posedge ref_clk);
		chk("top", stack_top, 10'h3aa);
		test_done();
	end

	// Watchdog well beyond the few hundred cycles the sequence needs
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		test_done();
	end
endmodule
